// ### hw/ugtp_defs.svh
/*
  Offsets, field positions, reset values and timing constants of the
  serial port guard-time and prescaler block.
  Assumes inclusion by bare name from hw/ sources.
*/
`ifndef UGTP_DEFS_SVH
`define UGTP_DEFS_SVH

// Register indices; byte address is four times the index
`define UGTP_IDX_STATUS 4'h0
`define UGTP_IDX_DATA 4'h1
`define UGTP_IDX_BRR1 4'h2
`define UGTP_IDX_BRR2 4'h3
`define UGTP_IDX_CR1 4'h4
`define UGTP_IDX_CR2 4'h5
`define UGTP_IDX_CR3 4'h6
`define UGTP_IDX_CR4 4'h7
`define UGTP_IDX_SPECIAL 4'h8
`define UGTP_IDX_GUARD 4'h9
`define UGTP_IDX_PRESC 4'ha
`define UGTP_IDX_IRQ_STATUS 4'hb
`define UGTP_IDX_IRQ_MASK 4'hc
`define UGTP_IDX_LINE 4'hd

// Bit positions
`define UGTP_BIT_TX_EMPTY 7
`define UGTP_BIT_DONE 6
`define UGTP_BIT_SMARTCARD 5
`define UGTP_BIT_IR_LOWPOWER 2
`define UGTP_BIT_INFRARED 1
`define UGTP_LINE_START 0
`define UGTP_IRQ_DONE 0
`define UGTP_IRQ_GUARD 1

// Reset values
`define UGTP_RST_SR 8'hc0
`define UGTP_RST_BYTE 8'h00

// Clock
`define UGTP_CLK_HZ 20000000
`define UGTP_CLK_NS 50
`endif

// ### hw/ugtp_divider.sv
/*
  Clock divider: one-cycle tick every 'divisor' clocks, restartable.
  Assumes divisor is nonzero whenever enable is high.
*/
`timescale 1ns/100ps
`default_nettype none
module ugtp_divider #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic enable,
  input wire logic restart,
  input wire logic [W-1:0] divisor,
  // Output
  output logic tick,
  output logic half
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_half;

  always_comb begin
    next_count = count;
    next_half = half;
    if (!enable || restart) begin
      next_count = '0;
      next_half = 1'b0;
    end else if (count >= divisor - W'(1)) begin
      next_count = '0;
      next_half = 1'b0;
    end else begin
      next_count = count + W'(1);
      if (next_count >= (divisor >> 1)) begin
        next_half = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      half <= 1'b0;
    end else begin
      count <= next_count;
      half <= next_half;
    end
  end

  assign tick = enable && !restart && (count >= divisor - W'(1));
endmodule : ugtp_divider
`default_nettype wire

// ### hw/ugtp_pkg.sv
/*
  Types of the guard-time and prescaler block.
  Assumes ugtp_defs.svh provides the numeric constants.
*/
package ugtp_pkg;
  typedef enum logic [1:0] {
    UGTP_IDLE = 2'b00,
    UGTP_FRAME = 2'b01,
    UGTP_GUARD = 2'b10
  } ugtp_state_t;
endpackage : ugtp_pkg

// ### hw/ugtp_top.sv
/*
  Serial port guard-time and prescaler logic with its register map on APB.
  Holds the smartcard and low-power infrared dividers, the guard counter
  and the event interrupt.
  Assumes a baud tick and frame-end pulse from the transmitter core, APB
  master synchronous to pclk, and software that avoids reserved values.
*/
// Overview of operation
// - In smartcard mode, transfer_done_flag waits guard_count baud periods after frame.
// - Infrared low-power clock divides source clock by full divide_value.
// - Smartcard clock divides source clock by twice low five prescaler bits.
// - Smartcard mode ignores prescaler bits seven to five.
// - Prescaler does not affect infrared timing while infrared disabled.
// - Prescaler does not affect smartcard clock while smartcard disabled.
// - smartcard_select bit in special_mode_control enables smartcard mode.
// - infrared_lowpower_select picks low power; infrared_select gates infrared.
`timescale 1ns/100ps
`default_nettype none
`include "ugtp_defs.svh"
module ugtp_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmitter core
  input wire logic baud_tick,
  input wire logic frame_end,
  // Line clocks
  output logic smartcard_clk,
  output logic infrared_lp_tick,
  // Interrupt
  output logic irq
);
  logic [7:0] line_status_flags;
  logic [7:0] data_buffer;
  logic [7:0] baud_divider_middle;
  logic [7:0] baud_divider_outer;
  logic [7:0] frame_parity_control;
  logic [7:0] enable_interrupt_control;
  logic [7:0] stop_sync_clock_control;
  logic [7:0] node_address_control;
  logic [7:0] special_mode_control;
  logic [7:0] guard_time;
  logic [7:0] clock_prescaler;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] guard_left;
  ugtp_pkg::ugtp_state_t state;

  logic [7:0] next_line_status_flags;
  logic [7:0] next_data_buffer;
  logic [7:0] next_baud_divider_middle;
  logic [7:0] next_baud_divider_outer;
  logic [7:0] next_frame_parity_control;
  logic [7:0] next_enable_interrupt_control;
  logic [7:0] next_stop_sync_clock_control;
  logic [7:0] next_node_address_control;
  logic [7:0] next_special_mode_control;
  logic [7:0] next_guard_time;
  logic [7:0] next_clock_prescaler;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic [7:0] next_guard_left;
  ugtp_pkg::ugtp_state_t next_state;
  logic [31:0] next_prdata;

  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [3:0] idx;
  logic smartcard_select;
  logic infrared_select;
  logic infrared_lowpower_select;
  logic [4:0] divide_value_sc;
  logic [7:0] divide_value;
  logic presc_written;
  logic done_event;
  logic guard_event;
  logic start_frame;
  logic sc_enable;
  logic ir_enable;
  logic sc_half;
  logic [3:0] rd_idx;

  assign idx = paddr[5:2];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00)
                   && (idx <= `UGTP_IDX_LINE);
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  // Unmapped or misaligned reads fall to the zero default
  assign rd_idx = addr_ok ? idx : 4'hf;

  assign smartcard_select = special_mode_control[`UGTP_BIT_SMARTCARD];
  assign infrared_select = special_mode_control[`UGTP_BIT_INFRARED];
  assign infrared_lowpower_select = special_mode_control[`UGTP_BIT_IR_LOWPOWER];
  assign divide_value = clock_prescaler;
  assign divide_value_sc = clock_prescaler[4:0];
  assign presc_written = wr_en && (idx == `UGTP_IDX_PRESC);
  // A start while a frame is pending is dropped
  assign start_frame = wr_en && (idx == `UGTP_IDX_LINE)
                       && pwdata[`UGTP_LINE_START]
                       && (state == ugtp_pkg::UGTP_IDLE);

  // Dividers run only in their mode and with a legal value
  assign sc_enable = smartcard_select && (divide_value_sc != 5'h0_0);
  assign ir_enable = infrared_select && infrared_lowpower_select
                     && (divide_value != 8'h00);

  // Smartcard divider counts twice the five-bit field
  ugtp_divider #(.W(6)) u_sc_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(sc_enable),
    .restart(presc_written),
    .divisor({divide_value_sc, 1'b0}),
    .tick(),
    .half(sc_half)
  );

  ugtp_divider #(.W(8)) u_ir_div (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ir_enable),
    .restart(presc_written),
    .divisor(divide_value),
    .tick(infrared_lp_tick),
    .half()
  );

  // Smartcard clock: high in second half of each divided period
  assign smartcard_clk = sc_enable && sc_half;

  // Frame and guard sequencing
  always_comb begin
    next_state = state;
    next_guard_left = guard_left;
    done_event = 1'b0;
    guard_event = 1'b0;
    case (state)
      ugtp_pkg::UGTP_IDLE: begin
        if (start_frame) begin
          next_state = ugtp_pkg::UGTP_FRAME;
        end
      end
      ugtp_pkg::UGTP_FRAME: begin
        if (frame_end) begin
          next_guard_left = guard_time;
          // Zero guard time gives no hold-off
          if (smartcard_select && guard_time != 8'h00) begin
            next_state = ugtp_pkg::UGTP_GUARD;
          end else begin
            next_state = ugtp_pkg::UGTP_IDLE;
            done_event = 1'b1;
          end
        end
      end
      ugtp_pkg::UGTP_GUARD: begin
        if (baud_tick) begin
          if (guard_left == 8'h01) begin
            next_state = ugtp_pkg::UGTP_IDLE;
            done_event = 1'b1;
            guard_event = 1'b1;
          end
          next_guard_left = guard_left - 8'h01;
        end
      end
      default: begin
        next_state = ugtp_pkg::UGTP_IDLE;
      end
    endcase
  end

  // Register file
  always_comb begin
    next_line_status_flags = line_status_flags;
    next_data_buffer = data_buffer;
    next_baud_divider_middle = baud_divider_middle;
    next_baud_divider_outer = baud_divider_outer;
    next_frame_parity_control = frame_parity_control;
    next_enable_interrupt_control = enable_interrupt_control;
    next_stop_sync_clock_control = stop_sync_clock_control;
    next_node_address_control = node_address_control;
    next_special_mode_control = special_mode_control;
    next_guard_time = guard_time;
    next_clock_prescaler = clock_prescaler;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_prdata = prdata;
    if (wr_en) begin
      case (idx)
        `UGTP_IDX_STATUS: begin
          // Done flag clears on a written zero
          if (!pwdata[`UGTP_BIT_DONE]) begin
            next_line_status_flags[`UGTP_BIT_DONE] = 1'b0;
          end
        end
        `UGTP_IDX_DATA: next_data_buffer = pwdata[7:0];
        `UGTP_IDX_BRR1: next_baud_divider_middle = pwdata[7:0];
        `UGTP_IDX_BRR2: next_baud_divider_outer = pwdata[7:0];
        `UGTP_IDX_CR1: next_frame_parity_control = pwdata[7:0];
        `UGTP_IDX_CR2: next_enable_interrupt_control = pwdata[7:0];
        `UGTP_IDX_CR3: next_stop_sync_clock_control = pwdata[7:0];
        `UGTP_IDX_CR4: next_node_address_control = {4'h0, pwdata[3:0]};
        `UGTP_IDX_SPECIAL: next_special_mode_control = pwdata[7:0];
        `UGTP_IDX_GUARD: next_guard_time = pwdata[7:0];
        `UGTP_IDX_PRESC: next_clock_prescaler = pwdata[7:0];
        `UGTP_IDX_IRQ_STATUS: next_irq_status = irq_status & ~pwdata[1:0];
        `UGTP_IDX_IRQ_MASK: next_irq_mask = pwdata[1:0];
        default: begin
        end
      endcase
    end
    if (start_frame) begin
      next_line_status_flags[`UGTP_BIT_DONE] = 1'b0;
    end
    // Hardware set wins over software clear
    if (done_event) begin
      next_line_status_flags[`UGTP_BIT_DONE] = 1'b1;
      next_irq_status[`UGTP_IRQ_DONE] = 1'b1;
    end
    if (guard_event) begin
      next_irq_status[`UGTP_IRQ_GUARD] = 1'b1;
    end
    // Transmit empty follows the idle state
    next_line_status_flags[`UGTP_BIT_TX_EMPTY] = (state == ugtp_pkg::UGTP_IDLE);
    if (rd_en) begin
      next_prdata = 32'h0000_0000;
      case (rd_idx)
        `UGTP_IDX_STATUS: next_prdata[7:0] = line_status_flags;
        `UGTP_IDX_DATA: next_prdata[7:0] = data_buffer;
        `UGTP_IDX_BRR1: next_prdata[7:0] = baud_divider_middle;
        `UGTP_IDX_BRR2: next_prdata[7:0] = baud_divider_outer;
        `UGTP_IDX_CR1: next_prdata[7:0] = frame_parity_control;
        `UGTP_IDX_CR2: next_prdata[7:0] = enable_interrupt_control;
        `UGTP_IDX_CR3: next_prdata[7:0] = stop_sync_clock_control;
        `UGTP_IDX_CR4: next_prdata[7:0] = node_address_control;
        `UGTP_IDX_SPECIAL: next_prdata[7:0] = special_mode_control;
        `UGTP_IDX_GUARD: next_prdata[7:0] = guard_time;
        `UGTP_IDX_PRESC: next_prdata[7:0] = clock_prescaler;
        `UGTP_IDX_IRQ_STATUS: next_prdata[1:0] = irq_status;
        `UGTP_IDX_IRQ_MASK: next_prdata[1:0] = irq_mask;
        `UGTP_IDX_LINE: next_prdata[7:0] = guard_left;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // State and register flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_status_flags <= `UGTP_RST_SR;
      data_buffer <= `UGTP_RST_BYTE;
      baud_divider_middle <= `UGTP_RST_BYTE;
      baud_divider_outer <= `UGTP_RST_BYTE;
      frame_parity_control <= `UGTP_RST_BYTE;
      enable_interrupt_control <= `UGTP_RST_BYTE;
      stop_sync_clock_control <= `UGTP_RST_BYTE;
      node_address_control <= `UGTP_RST_BYTE;
      special_mode_control <= `UGTP_RST_BYTE;
      guard_time <= `UGTP_RST_BYTE;
      clock_prescaler <= `UGTP_RST_BYTE;
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      guard_left <= `UGTP_RST_BYTE;
      state <= ugtp_pkg::UGTP_IDLE;
      prdata <= 32'h0000_0000;
    end else begin
      line_status_flags <= next_line_status_flags;
      data_buffer <= next_data_buffer;
      baud_divider_middle <= next_baud_divider_middle;
      baud_divider_outer <= next_baud_divider_outer;
      frame_parity_control <= next_frame_parity_control;
      enable_interrupt_control <= next_enable_interrupt_control;
      stop_sync_clock_control <= next_stop_sync_clock_control;
      node_address_control <= next_node_address_control;
      special_mode_control <= next_special_mode_control;
      guard_time <= next_guard_time;
      clock_prescaler <= next_clock_prescaler;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      guard_left <= next_guard_left;
      state <= next_state;
      prdata <= next_prdata;
    end
  end

  // Level interrupt while any unmasked event is pending
  assign irq = |(irq_status & irq_mask);
endmodule : ugtp_top
`default_nettype wire

// ### verification/tb_uart_guard_time_prescaler.sv
/* Bench: APB master, transmitter stand-in, queued read checks.
   Assumes zero-wait APB and byte address of index times four. */
`timescale 1ns/100ps
`default_nettype none
module tb_uart_guard_time_prescaler;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, baud_tick, frame_end, smartcard_clk, infrared_lp_tick, irq;
  logic [32:0] q[$];
  logic [7:0] cfg[7] = '{8'h06, 8'h02, 8'h04, 8'h20, 8'h26, 8'h00, 8'h26};
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'hac8f;
  int cyc = 0;
  always #25 pclk = ~pclk;
  ugtp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .baud_tick(baud_tick), .frame_end(frame_end),
    .smartcard_clk(smartcard_clk), .infrared_lp_tick(infrared_lp_tick), .irq(irq));
  ugtp_xmit_model xmit (.pclk(pclk), .presetn(presetn), .go(go),
    .baud_tick(baud_tick), .frame_end(frame_end));
  task automatic tally_and_finish;
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    q.push_back(e);
    wr(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic irq_is(input logic e);
    @(negedge pclk);
    chk("irq", {32'h0, irq}, {32'h0, e});
    @(posedge pclk);
  endtask : irq_is
  // Read monitor and run limit
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && !pwrite && q.size() > 0)
      chk("read", {pslverr, prdata}, q.pop_front());
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    logic [31:0] r;
    logic [7:0] p;
    logic ir, sc;
    int n, k;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 2; i <= 10; i++) rd(8'(i * 4), 33'h0_0000_0000);
    rd(8'h00, 33'h0_0000_00c0);
    rd(8'h38, 33'h1_0000_0000);
    rd(8'h25, 33'h1_0000_0000);
    for (int m = 0; m < 7; m++) begin
      r = $random(seed);
      p = (r[4:0] == 5'h00) ? (r[7:0] | 8'h01) : r[7:0];
      if (m == 6) p = 8'h00;
      wr(1'b1, 8'h20, {r[31:8], cfg[m]});
      wr(1'b1, 8'h28, {r[31:8], p});
      rd(8'h28, {25'h000_0000, p});
      ir = 1'b0;
      sc = 1'b0;
      repeat (520) begin
        @(negedge pclk);
        ir |= infrared_lp_tick;
        sc |= smartcard_clk;
      end
      chk("ir_tick", {32'h0, ir}, {32'h0, cfg[m][1] & cfg[m][2] & (p != 8'h00)});
      chk("sc_clk", {32'h0, sc}, {32'h0, cfg[m][5] & (p[4:0] != 5'h00)});
    end
    wr(1'b1, 8'h30, 32'h0000_0003);
    wr(1'b1, 8'h28, 32'h0000_0001);
    wr(1'b1, 8'h29, 32'h0000_00ff);
    rd(8'h28, 33'h0_0000_0001);
    for (int s = 0; s < 2; s++) begin
      r = $random(seed);
      p = 8'h01 + {5'h00, r[2:0]};
      wr(1'b1, 8'h24, {r[31:8], p});
      rd(8'h24, {25'h000_0000, p});
      rd(8'h25, 33'h1_0000_0000);
      wr(1'b1, 8'h20, s ? 32'h0000_0020 : 32'h0000_0000);
      wr(1'b1, 8'h34, 32'h0000_0001);
      rd(8'h00, 33'h0_0000_0000);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      k = 0;
      do begin
        @(negedge pclk);
        k++;
      end while (frame_end !== 1'b1 && k < 400);
      n = 0;
      while (irq !== 1'b1 && k < 400) begin
        n += baud_tick;
        @(negedge pclk);
        k++;
      end
      chk("guard_ticks", 33'(n), 33'(s ? p : 0));
      chk("guard_wait", 33'(k < 400), 33'h0_0000_0001);
      @(posedge pclk);
      if (s) begin
        rd(8'h2c, 33'h0_0000_0003);
        wr(1'b1, 8'h30, 32'h0000_0000);
        irq_is(1'b0);
        wr(1'b1, 8'h30, 32'h0000_0003);
        irq_is(1'b1);
      end
      rd(8'h00, 33'h0_0000_00c0);
      wr(1'b1, 8'h00, 32'h0000_0000);
      rd(8'h00, 33'h0_0000_0080);
      wr(1'b1, 8'h2c, 32'h0000_0003);
      irq_is(1'b0);
      rd(8'h2c, 33'h0_0000_0000);
    end
    tally_and_finish();
  end
endmodule : tb_uart_guard_time_prescaler
`default_nettype wire

// ### verification/ugtp_checker_assertions.sv
/* Port checks of the guard-time and prescaler block.
   Assumes byte address is index times four, one pclk domain. */
`timescale 1ns/100ps
`default_nettype none
module ugtp_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB and line clocks
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic smartcard_clk,
  input wire logic infrared_lp_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] dv, ctl, n_ir, n_sc;
  logic v_ir, v_sc, sc_q;
  wire logic acc = psel & penable;
  wire logic w_ctl = acc & pwrite & (paddr == 8'h20);
  wire logic w_dv = acc & pwrite & (paddr == 8'h28);
  wire logic chg = smartcard_clk ^ sc_q;
  // Shadow of mode and prescaler; cycles since each output last moved
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {dv, ctl, n_ir, n_sc} <= 32'h0000_0000;
      {v_ir, v_sc, sc_q} <= 3'h0;
    end else begin
      if (w_dv) dv <= pwdata[7:0];
      if (w_ctl) ctl <= pwdata[7:0];
      n_ir <= infrared_lp_tick ? 8'h01 : n_ir + 8'h01;
      n_sc <= chg ? 8'h01 : n_sc + 8'h01;
      v_ir <= !(w_ctl | w_dv) & (infrared_lp_tick | v_ir);
      v_sc <= !(w_ctl | w_dv) & (chg | v_sc);
      sc_q <= smartcard_clk;
    end
  end
  property p_err_bad; acc && (paddr[1:0] != 2'h0 || paddr > 8'h34) |-> pslverr; endproperty
  a_err_bad: assert property (p_err_bad)
    else $error("bad address not refused");
  property p_err_ok; acc && paddr[1:0] == 2'h0 && paddr <= 8'h34 |-> !pslverr; endproperty
  a_err_ok: assert property (p_err_ok)
    else $error("mapped address refused");
  property p_ir_per; infrared_lp_tick && v_ir |-> n_ir == dv; endproperty
  a_ir_per: assert property (p_ir_per)
    else $error("low-power tick spacing wrong");
  property p_ir_pulse;
    infrared_lp_tick && dv != 8'h01 && !w_dv |=> !infrared_lp_tick;
  endproperty
  a_ir_pulse: assert property (p_ir_pulse)
    else $error("low-power tick longer than one cycle");
  property p_sc_half; chg && v_sc |-> n_sc == {3'h0, dv[4:0]}; endproperty
  a_sc_half: assert property (p_sc_half)
    else $error("smartcard clock half period wrong");
  property p_ir_off; !(ctl[1] && ctl[2]) |-> !infrared_lp_tick; endproperty
  a_ir_off: assert property (p_ir_off)
    else $error("low-power tick while not selected");
  property p_sc_off; !ctl[5] |-> !smartcard_clk; endproperty
  a_sc_off: assert property (p_sc_off)
    else $error("smartcard clock while not selected");
  property p_zero; dv == 8'h00 |-> !infrared_lp_tick && !smartcard_clk; endproperty
  a_zero: assert property (p_zero)
    else $error("output with zero prescaler");
endmodule : ugtp_checker
bind ugtp_top ugtp_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .smartcard_clk(smartcard_clk), .infrared_lp_tick(infrared_lp_tick));
`default_nettype wire

// ### verification/ugtp_xmit_model.sv
/* Transmitter core stand-in: baud ticks and a frame-end pulse.
   Assumes go is a one-cycle pulse and BAUD is at least 2. */
`timescale 1ns/100ps
`default_nettype none
module ugtp_xmit_model #(
  parameter int BAUD = 3,
  parameter int BITS = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Frame control
  input wire logic go,
  output logic baud_tick,
  output logic frame_end
);
  int div;
  int left;
  // Frame end lands between baud ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 0;
      left <= 0;
      baud_tick <= 1'b0;
      frame_end <= 1'b0;
    end else begin
      div <= (div == BAUD - 1) ? 0 : div + 1;
      baud_tick <= (div == BAUD - 1);
      frame_end <= baud_tick && left == 1;
      if (go) left <= BITS;
      else if (baud_tick && left != 0) left <= left - 1;
    end
  end
endmodule : ugtp_xmit_model
`default_nettype wire
